// ### design/ptpts_client.sv
// client end: drives timers and per-frame commands, collects stamps
`timescale 1ns/1ps
module ptpts_client (
    // clock and reset
    input  wire logic                              clk,
    input  wire logic                              rst,
    // link to mac
    ptpts_if.client                                port,
    // user timers and controls
    input  wire logic [ptpts_pkg::TIMER_W-1:0]     tx_timer_in,
    input  wire logic [ptpts_pkg::TIMER_W-1:0]     rx_timer_in,
    input  wire logic                              one_step_enable,
    input  wire logic [ptpts_pkg::LAT_W-1:0]       latency_adjust,
    input  wire logic                              vlane_adjust_mode,
    input  wire logic                              transparent_mode,
    // user frame commands
    input  wire logic                              frame_sop,
    input  wire logic [ptpts_pkg::OP_W-1:0]        frame_timestamp_op,
    input  wire logic [ptpts_pkg::TAG_W-1:0]       frame_tag,
    input  wire logic                              rx_frame_sop,
    // user results
    output logic                                   stamp_valid,
    output logic      [ptpts_pkg::TAG_W-1:0]       stamp_tag,
    output logic      [ptpts_pkg::TIMER_W-1:0]     stamp,
    output logic      [ptpts_pkg::TIMER_W-1:0]     rx_stamp,
    output logic                                   error
);
    // ------------------------------------------------------------
    // drive side: everything registered on the mac clock
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            port.tx_timer           <= ptpts_pkg::TIMER_RESET;
            port.rx_timer           <= ptpts_pkg::TIMER_RESET;
            port.one_step_enable    <= 1'b0;
            port.latency_adjust     <= '0;
            port.vlane_adjust_mode  <= 1'b0;
            port.transparent_mode   <= 1'b0;
            port.tx_sop             <= 1'b0;
            port.frame_timestamp_op <= '0;
            port.tx_tag             <= ptpts_pkg::TAG_RESET;
            port.rx_sop             <= 1'b0;
        end else begin
            port.tx_timer           <= tx_timer_in;
            port.rx_timer           <= rx_timer_in;
            port.one_step_enable    <= one_step_enable;
            port.latency_adjust     <= latency_adjust;
            port.vlane_adjust_mode  <= vlane_adjust_mode;
            port.transparent_mode   <= transparent_mode;
            port.tx_sop             <= frame_sop;
            port.frame_timestamp_op <= frame_timestamp_op;
            port.tx_tag             <= frame_tag;
            port.rx_sop             <= rx_frame_sop;
        end
    end

    // ------------------------------------------------------------
    // collect side
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            stamp_valid <= 1'b0;
            stamp_tag   <= ptpts_pkg::TAG_RESET;
            stamp       <= ptpts_pkg::TIMER_RESET;
            rx_stamp    <= ptpts_pkg::TIMER_RESET;
            error       <= 1'b0;
        end else begin
            stamp_valid <= port.tx_tstamp_valid;
            stamp_tag   <= port.tx_tstamp_tag;
            stamp       <= port.tx_tstamp;
            rx_stamp    <= port.rx_tstamp;
            error       <= port.tag_write_error | port.tag_read_error;
        end
    end
endmodule

// ### design/ptpts_if.sv
// connection between client logic and the mac timestamp port
`timescale 1ns/1ps
interface ptpts_if;
    logic [ptpts_pkg::TIMER_W-1:0] tx_timer;
    logic [ptpts_pkg::TIMER_W-1:0] rx_timer;
    logic                          one_step_enable;
    logic [ptpts_pkg::LAT_W-1:0]   latency_adjust;
    logic                          vlane_adjust_mode;
    logic                          transparent_mode;
    logic                          tx_sop;
    logic [ptpts_pkg::OP_W-1:0]    frame_timestamp_op;
    logic [ptpts_pkg::TAG_W-1:0]   tx_tag;
    logic                          rx_sop;
    logic                          tx_tstamp_valid;
    logic [ptpts_pkg::TAG_W-1:0]   tx_tstamp_tag;
    logic [ptpts_pkg::TIMER_W-1:0] tx_tstamp;
    logic                          one_step_valid;
    logic [ptpts_pkg::TIMER_W-1:0] one_step_tstamp;
    logic [ptpts_pkg::TIMER_W-1:0] rx_tstamp;
    logic                          tag_write_error;
    logic                          tag_read_error;

    modport mac (
        input  tx_timer, rx_timer, one_step_enable, latency_adjust, vlane_adjust_mode,
        input  transparent_mode, tx_sop, frame_timestamp_op, tx_tag, rx_sop,
        output tx_tstamp_valid, tx_tstamp_tag, tx_tstamp, one_step_valid, one_step_tstamp,
        output rx_tstamp, tag_write_error, tag_read_error
    );
    modport client (
        output tx_timer, rx_timer, one_step_enable, latency_adjust, vlane_adjust_mode,
        output transparent_mode, tx_sop, frame_timestamp_op, tx_tag, rx_sop,
        input  tx_tstamp_valid, tx_tstamp_tag, tx_tstamp, one_step_valid, one_step_tstamp,
        input  rx_tstamp, tag_write_error, tag_read_error
    );
endinterface

// ### design/ptpts_mac.sv
// mac end: per-frame timestamp capture, 1-step adjust and 2-step return
`timescale 1ns/1ps
// Summary of operation
// - normal timer: 48-bit seconds, 32-bit nanoseconds
// - transparent timer: bit63 zero, ns, fraction
// - client drives tx timer on tx clock
// - client drives rx timer on lane0 clock
// - one-step enable input allows 1-step insertion
// - 1-step stamp offset by 11-bit latency adjust
// - accept single-bit virtual-lane adjust mode
// - transparent mode: timer is correction value
// - transparent mode adds correction to stamp
// - correction sign bit treated as zero
// - client pre-updates correction field with rx stamp
// - flag set on tag fifo write failure
// - flag set on tag fifo read failure
// - op 00: no stamp, frame unmodified
// - op 01: stamp captured and inserted
// - op 10: stamp returned on 2-step ports
// - op 11 behaves as no operation
// - client tag returned with its stamp
// - 80-bit 2-step stamp with valid strobe
module ptpts_mac (
    // clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // link to client
    ptpts_if.mac      port
);
    localparam int W  = ptpts_pkg::TIMER_W;
    localparam int FW = ptpts_pkg::TAG_W + ptpts_pkg::TIMER_W;

    // ------------------------------------------------------------
    // capture stage
    // ------------------------------------------------------------
    logic [W-1:0]                  cap_time;
    logic [ptpts_pkg::TAG_W-1:0]   cap_tag;
    logic                          cap_one;
    logic                          cap_two;
    logic [W-1:0]                  next_cap_time;
    logic [ptpts_pkg::TAG_W-1:0]   next_cap_tag;
    logic                          next_cap_one;
    logic                          next_cap_two;
    logic                          cap_tc;
    logic                          next_cap_tc;
    logic [W-1:0]                  cap_corr;
    logic [W-1:0]                  next_cap_corr;
    logic [ptpts_pkg::LAT_W-1:0]   cap_lat;
    logic [ptpts_pkg::LAT_W-1:0]   next_cap_lat;

    always_comb begin
        next_cap_one  = 1'b0;
        next_cap_two  = 1'b0;
        next_cap_time = cap_time;
        next_cap_tag  = cap_tag;
        next_cap_tc   = cap_tc;
        next_cap_corr = cap_corr;
        next_cap_lat  = cap_lat;
        if (port.tx_sop) begin
            // op and tag must be steady on this beat only
            unique case (ptpts_pkg::ptpts_op_e'(port.frame_timestamp_op))
                ptpts_pkg::PTPTS_OP_ONE_STEP: next_cap_one = port.one_step_enable;
                ptpts_pkg::PTPTS_OP_TWO_STEP: next_cap_two = 1'b1;
                ptpts_pkg::PTPTS_OP_NONE:     next_cap_one = 1'b0;
                ptpts_pkg::PTPTS_OP_RSVD:     next_cap_one = 1'b0;
            endcase
            next_cap_time = port.tx_timer;
            next_cap_tag  = port.tx_tag;
            next_cap_tc   = port.transparent_mode;
            // sign bit forced clear: corrections are always positive
            next_cap_corr = {{(W-ptpts_pkg::TC_SIGN_BIT){1'b0}}, port.tx_timer[ptpts_pkg::TC_SIGN_BIT-1:0]};
            next_cap_lat  = port.latency_adjust;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cap_one  <= 1'b0;
            cap_two  <= 1'b0;
            cap_time <= ptpts_pkg::TIMER_RESET;
            cap_tag  <= ptpts_pkg::TAG_RESET;
            cap_tc   <= 1'b0;
            cap_corr <= ptpts_pkg::TIMER_RESET;
            cap_lat  <= '0;
        end else begin
            cap_one  <= next_cap_one;
            cap_two  <= next_cap_two;
            cap_time <= next_cap_time;
            cap_tag  <= next_cap_tag;
            cap_tc   <= next_cap_tc;
            cap_corr <= next_cap_corr;
            cap_lat  <= next_cap_lat;
        end
    end

    // ------------------------------------------------------------
    // stamp arithmetic
    // ------------------------------------------------------------
    localparam int NSW = ptpts_pkg::NS_W;
    localparam logic [NSW:0] NS_WRAP = (NSW+1)'(ptpts_pkg::NS_PER_SEC);

    logic [W-1:0]  base_stamp;
    logic [W-1:0]  adj_stamp;
    logic [63:0]   tc_sum;
    logic [NSW:0]  ns_sum;
    logic [ptpts_pkg::SEC_W-1:0] sec_sum;

    always_comb begin
        // transparent mode: correction carried as ns plus 16-bit fraction
        // whole ns of the adjust land at bit 16, its fraction at bits 15:13
        tc_sum = cap_corr[63:0] + (64'(cap_lat) << (ptpts_pkg::TC_NS_LSB - ptpts_pkg::LAT_FRAC_W));
        tc_sum[ptpts_pkg::TC_SIGN_BIT] = 1'b0;
        // normal mode: fraction bits of the adjust dropped, only whole ns apply
        ns_sum  = {1'b0, cap_time[NSW-1:0]} +
                  (NSW+1)'(cap_lat[ptpts_pkg::LAT_W-1:ptpts_pkg::LAT_FRAC_W]);
        sec_sum = cap_time[W-1:NSW];
        if (ns_sum >= NS_WRAP) begin
            ns_sum  = ns_sum - NS_WRAP;
            sec_sum = sec_sum + 1'b1;
        end
        base_stamp = cap_tc ? {16'h0, cap_corr[63:0]} : cap_time;
        adj_stamp  = cap_tc ? {16'h0, tc_sum} : {sec_sum, ns_sum[NSW-1:0]};
    end

    // ------------------------------------------------------------
    // tag fifo and outputs
    // ------------------------------------------------------------
    logic [FW-1:0] fifo_out;
    logic          fifo_empty;
    logic          fifo_werr;
    logic          fifo_rerr;
    logic          pop;

    ptpts_tag_fifo #(
        .WIDTH (FW),
        .DEPTH (ptpts_pkg::TAG_FIFO_DEPTH)
    ) u_fifo (
        .clk         (clk),
        .rst         (rst),
        .wr_en       (cap_two),
        .wr_data     ({cap_tag, base_stamp}),
        .rd_en       (pop),
        .rd_data     (fifo_out),
        .empty       (fifo_empty),
        .write_error (fifo_werr),
        .read_error  (fifo_rerr)
    );

    // ------------------------------------------------------------
    // tx outputs
    // ------------------------------------------------------------
    logic                        next_tx_valid;
    logic [ptpts_pkg::TAG_W-1:0] next_tx_tag;
    logic [W-1:0]                next_tx_stamp;
    logic                        next_one_valid;
    logic [W-1:0]                next_one_stamp;
    logic                        next_write_error;
    logic                        next_read_error;

    always_comb begin
        // draining every cycle keeps the fifo near empty; vlane mode is accepted, no skew model
        pop              = !fifo_empty;
        next_tx_valid    = pop;
        next_tx_tag      = pop ? fifo_out[FW-1:W] : port.tx_tstamp_tag;
        next_tx_stamp    = pop ? fifo_out[W-1:0] : port.tx_tstamp;
        next_one_valid   = cap_one;
        next_one_stamp   = cap_one ? adj_stamp : port.one_step_tstamp;
        next_write_error = fifo_werr;
        next_read_error  = fifo_rerr;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            port.tx_tstamp_valid <= 1'b0;
            port.tx_tstamp_tag   <= ptpts_pkg::TAG_RESET;
            port.tx_tstamp       <= ptpts_pkg::TIMER_RESET;
            port.one_step_valid  <= 1'b0;
            port.one_step_tstamp <= ptpts_pkg::TIMER_RESET;
            port.tag_write_error <= 1'b0;
            port.tag_read_error  <= 1'b0;
        end else begin
            port.tx_tstamp_valid <= next_tx_valid;
            port.tx_tstamp_tag   <= next_tx_tag;
            port.tx_tstamp       <= next_tx_stamp;
            port.one_step_valid  <= next_one_valid;
            port.one_step_tstamp <= next_one_stamp;
            port.tag_write_error <= next_write_error;
            port.tag_read_error  <= next_read_error;
        end
    end

    // ------------------------------------------------------------
    // rx capture
    // ------------------------------------------------------------
    logic [W-1:0] next_rx_stamp;

    always_comb begin
        // loads on the sop beat and holds until the next one
        next_rx_stamp = port.rx_sop ? port.rx_timer : port.rx_tstamp;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            port.rx_tstamp <= ptpts_pkg::TIMER_RESET;
        end else begin
            port.rx_tstamp <= next_rx_stamp;
        end
    end
endmodule

// ### design/ptpts_pkg.sv
// shared constants and types for the ptp timestamp port logic
package ptpts_pkg;
    // ------------------------------------------------------------
    // timer layout
    // ------------------------------------------------------------
    localparam int TIMER_W       = 80;
    localparam int SEC_W         = 48;
    localparam int NS_W          = 32;
    localparam int TC_SIGN_BIT   = 63;
    localparam int TC_NS_LSB     = 16;
    localparam int TC_FRAC_W     = 16;
    localparam int LAT_W         = 11;
    localparam int LAT_FRAC_W    = 3;
    localparam int TAG_W         = 16;
    localparam int OP_W          = 2;
    localparam int TAG_FIFO_DEPTH = 4;
    localparam int unsigned NS_PER_SEC = 1000000000;
    localparam logic [TIMER_W-1:0] TIMER_RESET = 80'h0;
    localparam logic [TAG_W-1:0]   TAG_RESET   = 16'h0;

    // ------------------------------------------------------------
    // per-frame operation codes
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        PTPTS_OP_NONE     = 2'h0,
        PTPTS_OP_ONE_STEP = 2'h1,
        PTPTS_OP_TWO_STEP = 2'h2,
        PTPTS_OP_RSVD     = 2'h3
    } ptpts_op_e;
endpackage

// ### design/ptpts_tag_fifo.sv
// small tag fifo with sticky overflow and underflow flags
`timescale 1ns/1ps
module ptpts_tag_fifo #(
    parameter int WIDTH = ptpts_pkg::TAG_W + ptpts_pkg::TIMER_W,
    parameter int DEPTH = ptpts_pkg::TAG_FIFO_DEPTH
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             rst,
    // write side
    input  wire logic             wr_en,
    input  wire logic [WIDTH-1:0] wr_data,
    // read side
    input  wire logic             rd_en,
    output logic      [WIDTH-1:0] rd_data,
    output logic                  empty,
    // sticky errors
    output logic                  write_error,
    output logic                  read_error
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [AW:0]      count;
    logic [AW-1:0]    next_wr_ptr;
    logic [AW-1:0]    next_rd_ptr;
    logic [AW:0]      next_count;
    logic             next_write_error;
    logic             next_read_error;
    logic             do_wr;
    logic             do_rd;

    always_comb begin
        do_wr            = wr_en && (count != (AW+1)'(DEPTH));
        do_rd            = rd_en && (count != '0);
        next_wr_ptr      = do_wr ? ((wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1) : wr_ptr;
        next_rd_ptr      = do_rd ? ((rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1) : rd_ptr;
        next_count       = count + (AW+1)'(do_wr) - (AW+1)'(do_rd);
        // only reset clears them; writing into a full fifo drops the tag
        next_write_error = write_error || (wr_en && !do_wr);
        next_read_error  = read_error || (rd_en && !do_rd);
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wr_ptr      <= '0;
            rd_ptr      <= '0;
            count       <= '0;
            write_error <= 1'b0;
            read_error  <= 1'b0;
        end else begin
            wr_ptr      <= next_wr_ptr;
            rd_ptr      <= next_rd_ptr;
            count       <= next_count;
            write_error <= next_write_error;
            read_error  <= next_read_error;
        end
    end

    always_ff @(posedge clk) begin
        if (do_wr) begin
            mem[wr_ptr] <= wr_data;
        end
    end

    assign rd_data = mem[rd_ptr];
    assign empty   = (count == '0);
endmodule

// ### tb/ptpts_assertions.sv
// concurrent checks on the client to mac timestamp link
`timescale 1ns/1ps
module ptpts_assertions (
    // clock and reset
    input wire logic                          clk,
    input wire logic                          rst,
    // client side
    input wire logic [ptpts_pkg::TIMER_W-1:0] tx_timer,
    input wire logic [ptpts_pkg::TIMER_W-1:0] rx_timer,
    input wire logic                          one_step_enable,
    input wire logic                          transparent_mode,
    input wire logic                          tx_sop,
    input wire logic [ptpts_pkg::OP_W-1:0]    frame_timestamp_op,
    input wire logic [ptpts_pkg::TAG_W-1:0]   tx_tag,
    input wire logic                          rx_sop,
    // mac side
    input wire logic                          tx_tstamp_valid,
    input wire logic [ptpts_pkg::TAG_W-1:0]   tx_tstamp_tag,
    input wire logic [ptpts_pkg::TIMER_W-1:0] tx_tstamp,
    input wire logic                          one_step_valid,
    input wire logic [ptpts_pkg::TIMER_W-1:0] one_step_tstamp,
    input wire logic [ptpts_pkg::TIMER_W-1:0] rx_tstamp,
    input wire logic                          tag_write_error,
    input wire logic                          tag_read_error
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    // ------------------------------------------------------------
    // tx path
    // ------------------------------------------------------------
    a_two_step_latency: assert property (tx_sop && frame_timestamp_op == 2'h2 |-> ##3 tx_tstamp_valid)
        else $error("two-step stamp not returned three cycles after sop");
    a_stamp_has_cause: assert property (tx_tstamp_valid |-> $past(tx_sop, 3) && $past(frame_timestamp_op, 3) == 2'h2)
        else $error("two-step stamp without a two-step frame");
    a_tag_with_stamp: assert property (tx_tstamp_valid |-> tx_tstamp_tag == $past(tx_tag, 3))
        else $error("returned tag differs from frame tag");
    a_normal_stamp_value: assert property (tx_tstamp_valid && !$past(transparent_mode, 3) |-> tx_tstamp == $past(tx_timer, 3))
        else $error("two-step stamp is not the timer at sop");
    a_tc_stamp_value: assert property (tx_tstamp_valid && $past(transparent_mode, 3)
        |-> tx_tstamp == {16'h0, 1'h0, $past(tx_timer[62:0], 3)})
        else $error("transparent two-step stamp malformed");
    a_one_step_latency: assert property (tx_sop && frame_timestamp_op == 2'h1 && one_step_enable |-> ##2 one_step_valid)
        else $error("one-step stamp missing two cycles after sop");
    a_one_step_gate: assert property (one_step_valid
        |-> $past(tx_sop, 2) && $past(frame_timestamp_op, 2) == 2'h1 && $past(one_step_enable, 2))
        else $error("one-step stamp without an enabled one-step frame");
    a_tc_sign_clear: assert property (one_step_valid && $past(transparent_mode, 2) |-> one_step_tstamp[79:63] == 17'h0)
        else $error("transparent one-step stamp has sign or upper bits set");
    // ------------------------------------------------------------
    // rx path and errors
    // ------------------------------------------------------------
    a_rx_capture: assert property (rx_sop |=> rx_tstamp == $past(rx_timer))
        else $error("rx stamp is not the timer at rx sop");
    a_rx_hold: assert property (!rx_sop |=> $stable(rx_tstamp))
        else $error("rx stamp changed without rx sop");
    a_err_sticky: assert property (!$fell(tag_write_error) && !$fell(tag_read_error))
        else $error("tag fifo error flag cleared without reset");

    c_two_step: cover property (tx_tstamp_valid && $past(tx_tstamp_valid));
    c_one_step_tc: cover property (one_step_valid && $past(transparent_mode, 2));
    c_rx_sop: cover property (rx_sop);
endmodule

// ### tb/testbench.sv
// self-checking bench joining client and mac ends
`timescale 1ns/1ps
module testbench;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [79:0] tx_timer_in = 80'h0;
    logic [79:0] rx_timer_in = 80'h0;
    logic        one_step_enable = 1'b0;
    logic [10:0] latency_adjust = 11'h0;
    logic        vlane_adjust_mode = 1'b0;
    logic        transparent_mode = 1'b0;
    logic        frame_sop = 1'b0;
    logic [1:0]  frame_timestamp_op = 2'h0;
    logic [15:0] frame_tag = 16'h0;
    logic        rx_frame_sop = 1'b0;
    logic        stamp_valid;
    logic [15:0] stamp_tag;
    logic [79:0] stamp;
    logic [79:0] rx_stamp;
    logic        error;
    logic [95:0] two_q[$];
    logic [79:0] one_q[$];
    logic [79:0] rx_hold;
    int          n_errors = 0;
    int          n_tests = 0;

    always #20 clk = ~clk;

    ptpts_if link ();
    ptpts_mac ptpts_mac_i (.clk(clk), .rst(rst), .port(link));
    ptpts_client ptpts_client_i (
        .clk(clk), .rst(rst), .port(link), .tx_timer_in(tx_timer_in), .rx_timer_in(rx_timer_in),
        .one_step_enable(one_step_enable), .latency_adjust(latency_adjust),
        .vlane_adjust_mode(vlane_adjust_mode), .transparent_mode(transparent_mode),
        .frame_sop(frame_sop), .frame_timestamp_op(frame_timestamp_op), .frame_tag(frame_tag),
        .rx_frame_sop(rx_frame_sop), .stamp_valid(stamp_valid), .stamp_tag(stamp_tag),
        .stamp(stamp), .rx_stamp(rx_stamp), .error(error)
    );
    ptpts_assertions ptpts_assertions_i (
        .clk(clk), .rst(rst), .tx_timer(link.tx_timer), .rx_timer(link.rx_timer),
        .one_step_enable(link.one_step_enable), .transparent_mode(link.transparent_mode),
        .tx_sop(link.tx_sop), .frame_timestamp_op(link.frame_timestamp_op), .tx_tag(link.tx_tag),
        .rx_sop(link.rx_sop), .tx_tstamp_valid(link.tx_tstamp_valid), .tx_tstamp_tag(link.tx_tstamp_tag),
        .tx_tstamp(link.tx_tstamp), .one_step_valid(link.one_step_valid),
        .one_step_tstamp(link.one_step_tstamp), .rx_tstamp(link.rx_tstamp),
        .tag_write_error(link.tag_write_error), .tag_read_error(link.tag_read_error)
    );

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic check(input string name, input logic [95:0] seen, input logic [95:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    function automatic logic [79:0] exp_two(input logic [79:0] t, input logic tc);
        return tc ? {16'h0, 1'h0, t[62:0]} : t;
    endfunction

    // ns carry into seconds; latency fraction is dropped in normal mode
    function automatic logic [79:0] exp_one(input logic [79:0] t, input logic tc, input logic [10:0] lat);
        logic [63:0] s;
        logic [32:0] ns;
        logic [47:0] sec;
        s = {1'h0, t[62:0]} + ({53'h0, lat} << 13);
        ns = {1'h0, t[31:0]} + {25'h0, lat[10:3]};
        sec = t[79:32];
        if (ns >= ptpts_pkg::NS_PER_SEC) begin
            ns = ns - ptpts_pkg::NS_PER_SEC;
            sec = sec + 48'h1;
        end
        return tc ? {16'h0, 1'h0, s[62:0]} : {sec, ns[31:0]};
    endfunction

    function automatic logic [79:0] norm_timer();
        return {48'({$urandom(), $urandom()}), 32'($urandom() % ptpts_pkg::NS_PER_SEC)};
    endfunction

    // one frame start per call; calls back to back give sops on consecutive cycles
    task automatic send(input logic [1:0] op, input logic [79:0] t);
        logic [15:0] tag;
        tag = 16'($urandom());
        @(negedge clk);
        frame_sop = 1'b1;
        frame_timestamp_op = op;
        frame_tag = tag;
        tx_timer_in = t;
        vlane_adjust_mode = 1'($urandom());
        if (op == 2'h2) two_q.push_back({tag, exp_two(t, transparent_mode)});
        if (op == 2'h1 && one_step_enable) one_q.push_back(exp_one(t, transparent_mode, latency_adjust));
    endtask

    task automatic idle(input int n);
        repeat (n) begin
            @(negedge clk);
            frame_sop = 1'b0;
            tx_timer_in = norm_timer();
        end
    endtask

    // ------------------------------------------------------------
    // result monitor
    // ------------------------------------------------------------
    always @(negedge clk) begin
        if (!rst && stamp_valid === 1'b1) begin
            if (two_q.size() == 0) check("unexpected two-step", {95'h0, stamp_valid}, 96'h0);
            else check("two-step tag and stamp", {stamp_tag, stamp}, two_q.pop_front());
        end
        if (!rst && link.one_step_valid === 1'b1) begin
            if (one_q.size() == 0) check("unexpected one-step", 96'h1, 96'h0);
            else check("one-step stamp", {16'h0, link.one_step_tstamp}, {16'h0, one_q.pop_front()});
        end
    end

    initial begin
        #(40 * 3000);
        n_errors++;
        wrap_up();
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        void'($urandom(41883));
        repeat (8) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        latency_adjust = 11'($urandom());
        // every op code with one-step disabled then enabled
        for (int en = 0; en < 2; en++) begin
            one_step_enable = 1'(en);
            for (int i = 0; i < 8; i++) send(2'(i), norm_timer());
            idle(3);
        end
        // nanosecond wrap at latency 7FD, the largest whole-ns adjust of 255
        latency_adjust = 11'h7FD;
        send(2'h1, {48'h0000FFFFFFFF, 32'(ptpts_pkg::NS_PER_SEC - 10)});
        send(2'h1, {48'h123456789ABC, 32'(ptpts_pkg::NS_PER_SEC - 1)});
        send(2'h2, {48'h123456789ABC, 32'(ptpts_pkg::NS_PER_SEC - 1)});
        send(2'h2, norm_timer());
        idle(3);
        // transparent mode, one-step and two-step alternating, sign bit left random
        transparent_mode = 1'b1;
        for (int i = 0; i < 12; i++) begin
            // gap cycle keeps the new adjust off the frame just sent
            idle(1);
            latency_adjust = 11'($urandom());
            send(2'(1 + (i % 2)), {$urandom(), $urandom(), 16'($urandom())});
        end
        idle(10);
        check("pending two-step", 96'(two_q.size()), 96'h0);
        check("pending one-step", 96'(one_q.size()), 96'h0);
        // rx capture then timer moves on
        @(negedge clk);
        rx_hold = norm_timer();
        rx_timer_in = rx_hold;
        rx_frame_sop = 1'b1;
        @(negedge clk);
        rx_frame_sop = 1'b0;
        rx_timer_in = ~rx_hold;
        repeat (4) @(negedge clk);
        check("rx stamp", {16'h0, rx_stamp}, {16'h0, rx_hold});
        check("tag fifo error", {95'h0, error}, 96'h0);
        wrap_up();
    end
endmodule
